// ==== verilog/bit_op_map.svh ====
// Constants for the single-bit set and clear executor.
`ifndef BIT_OP_MAP_SVH
`define BIT_OP_MAP_SVH
`define BIT_OP_OPCODE      4'h8
`define BIT_OP_OPC_HI      15
`define BIT_OP_OPC_LO      12
`define BIT_OP_SEL_BIT     11
`define BIT_OP_POS_HI      10
`define BIT_OP_POS_LO      8
`define BIT_OP_ADDR_HI     7
`define BIT_OP_ADDR_LO     0
`define BIT_OP_SEL_CLEAR   1'h1
`define BIT_OP_DATA_RST    8'h00
`define BIT_OP_ADDR_RST    8'h00
`define BIT_OP_POS_RST     3'h0
`endif

// ==== verilog/bit_op_pkg.sv ====
// Types for the single-bit set and clear executor.
package bit_op_pkg;
	typedef enum logic [1:0] {
		Q1_DECODE = 2'b00,
		Q2_READ   = 2'b01,
		Q3_MODIFY = 2'b10,
		Q4_WRITE  = 2'b11
	} quarter_t;
	typedef enum logic [1:0] {
		OP_NONE   = 2'b00,
		OP_SET    = 2'b01,
		OP_CLEAR  = 2'b10
	} bit_op_t;
endpackage

// ==== verilog/bit_set_clear_exec.sv ====
// Decode and execution of the single-bit set and clear instructions.
`timescale 1ns/1ps
`include "bit_op_map.svh"
module bit_set_clear_exec
	import bit_op_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic [15:0] instr_word,
	input  wire logic        instr_valid,
	input  wire logic [7:0]  mem_rdata,
	output logic             mem_rd_en,
	output logic [7:0]       mem_addr,
	output logic             mem_wr_en,
	output logic [7:0]       mem_wdata,
	output logic [1:0]       quarter,
	output logic             op_done,
	output logic             op_is_clear,
	output logic             flags_wr_en
);
	logic       rst_s1_ff;
	logic       rst_s2_ff;
	quarter_t   q_ff;
	quarter_t   nxt_q;
	bit_op_t    op_ff;
	bit_op_t    nxt_op;
	logic [2:0] pos_ff;
	logic [2:0] nxt_pos;
	logic [7:0] addr_ff;
	logic [7:0] nxt_addr;
	logic [7:0] data_ff;
	logic [7:0] nxt_data;
	logic       rd_en_ff;
	logic       nxt_rd_en;
	logic       wr_en_ff;
	logic       nxt_wr_en;
	logic       done_ff;
	logic       nxt_done;
	logic       clear_ff;
	logic       nxt_clear;
	logic       flags_ff;
	logic       nxt_flags;
	wire        in_q1;
	wire        in_q2;
	wire        in_q3;
	wire  [3:0] opc_field;
	wire        opc_match;
	wire        is_bit_op;
	wire        sel_clear;
	wire  [2:0] pos_field;
	wire  [7:0] addr_field;
	wire        take_op;
	wire        op_live;
	wire        want_set;
	wire  [7:0] modified;

	// Reset is released through two flops so every flop reset by rst_s2_ff leaves reset on the same edge.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_s1_ff <= 1'h0;
			rst_s2_ff <= 1'h0;
		end else begin
			rst_s1_ff <= 1'h1;
			rst_s2_ff <= rst_s1_ff;
		end
	end

	assign in_q1      = (q_ff == Q1_DECODE);
	assign in_q2      = (q_ff == Q2_READ);
	assign in_q3      = (q_ff == Q3_MODIFY);
	assign opc_field  = instr_word[`BIT_OP_OPC_HI:`BIT_OP_OPC_LO];
	assign opc_match  = (opc_field == `BIT_OP_OPCODE);
	assign is_bit_op  = instr_valid && opc_match;
	assign sel_clear  = (instr_word[`BIT_OP_SEL_BIT] == `BIT_OP_SEL_CLEAR);
	assign pos_field  = instr_word[`BIT_OP_POS_HI:`BIT_OP_POS_LO];
	assign addr_field = instr_word[`BIT_OP_ADDR_HI:`BIT_OP_ADDR_LO];
	// A word is only taken at the end of the first quarter; a word still held at the next first quarter is taken again.
	assign take_op    = in_q1 && is_bit_op;
	assign op_live    = (op_ff != OP_NONE);
	assign want_set   = (op_ff == OP_SET);

	// Each bit keeps its read value unless it is the selected one.
	for (genvar i = 0; i < 8; i++) begin : g_bit
		wire hit;
		assign hit         = (pos_ff == 3'(i));
		assign modified[i] = hit ? want_set : data_ff[i];
	end

	always_comb begin
		nxt_q = Q1_DECODE;
		case (q_ff)
			Q1_DECODE: nxt_q = Q2_READ;
			Q2_READ:   nxt_q = Q3_MODIFY;
			Q3_MODIFY: nxt_q = Q4_WRITE;
			Q4_WRITE:  nxt_q = Q1_DECODE;
			default:   nxt_q = Q1_DECODE;
		endcase
	end

	always_comb begin
		nxt_op = op_ff;
		if (in_q1) begin
			if (!is_bit_op) begin
				nxt_op = OP_NONE;
			end else if (sel_clear) begin
				nxt_op = OP_CLEAR;
			end else begin
				nxt_op = OP_SET;
			end
		end
	end

	always_comb begin
		nxt_data = data_ff;
		if (in_q2) begin
			nxt_data = mem_rdata;
		end else if (in_q3) begin
			nxt_data = modified;
		end
	end

	// Strobes are registered one quarter ahead so they stand during their own quarter.
	assign nxt_pos   = take_op ? pos_field : pos_ff;
	assign nxt_addr  = take_op ? addr_field : addr_ff;
	assign nxt_rd_en = take_op;
	assign nxt_wr_en = in_q3 && op_live;
	assign nxt_done  = in_q3 && op_live;
	assign nxt_clear = (nxt_op == OP_CLEAR);
	// Status flags are never written by these instructions.
	assign nxt_flags = 1'h0;

	always_ff @(posedge clock or negedge rst_s2_ff) begin
		if (!rst_s2_ff) begin
			q_ff <= Q1_DECODE;
		end else begin
			q_ff <= nxt_q;
		end
	end

	always_ff @(posedge clock or negedge rst_s2_ff) begin
		if (!rst_s2_ff) begin
			op_ff <= OP_NONE;
		end else begin
			op_ff <= nxt_op;
		end
	end

	always_ff @(posedge clock or negedge rst_s2_ff) begin
		if (!rst_s2_ff) begin
			pos_ff <= `BIT_OP_POS_RST;
		end else begin
			pos_ff <= nxt_pos;
		end
	end

	always_ff @(posedge clock or negedge rst_s2_ff) begin
		if (!rst_s2_ff) begin
			addr_ff <= `BIT_OP_ADDR_RST;
		end else begin
			addr_ff <= nxt_addr;
		end
	end

	always_ff @(posedge clock or negedge rst_s2_ff) begin
		if (!rst_s2_ff) begin
			data_ff <= `BIT_OP_DATA_RST;
		end else begin
			data_ff <= nxt_data;
		end
	end

	always_ff @(posedge clock or negedge rst_s2_ff) begin
		if (!rst_s2_ff) begin
			rd_en_ff <= 1'h0;
		end else begin
			rd_en_ff <= nxt_rd_en;
		end
	end

	always_ff @(posedge clock or negedge rst_s2_ff) begin
		if (!rst_s2_ff) begin
			wr_en_ff <= 1'h0;
		end else begin
			wr_en_ff <= nxt_wr_en;
		end
	end

	always_ff @(posedge clock or negedge rst_s2_ff) begin
		if (!rst_s2_ff) begin
			done_ff <= 1'h0;
		end else begin
			done_ff <= nxt_done;
		end
	end

	always_ff @(posedge clock or negedge rst_s2_ff) begin
		if (!rst_s2_ff) begin
			clear_ff <= 1'h0;
		end else begin
			clear_ff <= nxt_clear;
		end
	end

	// Kept as a flop so the output is as clean as the others, even though it never rises.
	always_ff @(posedge clock or negedge rst_s2_ff) begin
		if (!rst_s2_ff) begin
			flags_ff <= 1'h0;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	assign mem_rd_en   = rd_en_ff;
	assign mem_wr_en   = wr_en_ff;
	assign mem_addr    = addr_ff;
	assign mem_wdata   = data_ff;
	assign quarter     = q_ff;
	assign op_done     = done_ff;
	assign op_is_clear = clear_ff;
	assign flags_wr_en = flags_ff;
endmodule // bit_set_clear_exec

// ==== dv/bsc_asserts.sv ====
// Checker for the bit set and clear executor.
`timescale 1ns/1ps
module bsc_asserts (
	input wire logic	clock,
	input wire logic	rstn,
	input wire logic [15:0]	instr_word,
	input wire logic	instr_valid,
	input wire logic [7:0]	mem_rdata,
	input wire logic	mem_rd_en,
	input wire logic [7:0]	mem_addr,
	input wire logic	mem_wr_en,
	input wire logic [7:0]	mem_wdata,
	input wire logic [1:0]	quarter,
	input wire logic	op_done,
	input wire logic	op_is_clear,
	input wire logic	flags_wr_en
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	wire	dec = quarter == 2'h0 && instr_valid && instr_word[15:12] == 4'h8;
	chk_quarter_flow:
	assert property (dec |=> mem_rd_en && mem_addr == $past(instr_word[7:0]) ##2 mem_wr_en)
		else $error("bad quarter flow");
	chk_clear_bit:
	assert property (mem_wr_en && op_is_clear |-> mem_wdata ==
		($past(mem_rdata, 2) & ~(8'h01 << $past(instr_word[10:8], 3)))) else $error("bad clear");
	chk_set_bit:
	assert property (mem_wr_en && !op_is_clear |-> mem_wdata ==
		($past(mem_rdata, 2) | (8'h01 << $past(instr_word[10:8], 3)))) else $error("bad set");
	chk_flags_kept:
	assert property (!flags_wr_en) else $error("flags written");
	chk_refused_word:
	assert property (quarter == 2'h0 && !dec |=> !mem_rd_en ##2 !mem_wr_en) else $error("bad op");
	chk_done_with_write:
	assert property (op_done == mem_wr_en) else $error("done pulse not with write");
endmodule // bsc_asserts
bind bit_set_clear_exec bsc_asserts u_bsc_asserts (
	.clock       (clock),
	.rstn        (rstn),
	.instr_word  (instr_word),
	.instr_valid (instr_valid),
	.mem_rdata   (mem_rdata),
	.mem_rd_en   (mem_rd_en),
	.mem_addr    (mem_addr),
	.mem_wr_en   (mem_wr_en),
	.mem_wdata   (mem_wdata),
	.quarter     (quarter),
	.op_done     (op_done),
	.op_is_clear (op_is_clear),
	.flags_wr_en (flags_wr_en)
);

// ==== dv/rf_model.sv ====
// Register file at the executor's data-memory port.
`timescale 1ns/1ps
module rf_model (
	input wire logic	clock,
	input wire logic	mem_rd_en,
	input wire logic	mem_wr_en,
	input wire logic [7:0]	mem_addr,
	input wire logic [7:0]	mem_wdata,
	output logic [7:0]	mem_rdata
);
	logic [7:0]	regs [256];
	// Outside a read the bus shows the inverse, so stale data cannot pass as valid.
	assign mem_rdata = mem_rd_en ? regs[mem_addr] : ~regs[mem_addr];
	always @(posedge clock) if (mem_wr_en) regs[mem_addr] <= mem_wdata;
endmodule // rf_model

// ==== dv/bit_set_clear_exec_tb.sv ====
// Testbench for the bit set and clear executor.
`timescale 1ns/1ps
module bit_set_clear_exec_tb;
	logic	clock = 0, rstn = 0, instr_valid = 0, mem_rd_en, mem_wr_en;
	logic	op_done, op_is_clear, flags_wr_en;
	logic [15:0]	instr_word = 16'h0000;
	logic [7:0]	mem_rdata, mem_addr, mem_wdata;
	logic [1:0]	quarter;
	int	n_mismatch = 0, n_checks = 0;
	logic [32:0]	rows [8] = '{33'h1_8f55_c7_47, 33'h1_87aa_0a_8a, 33'h1_88ff_01_00,
		33'h1_8000_00_01, 33'h1_9755_80_80, 33'h0_8811_ff_ff, 33'h1_8b3c_ff_f7,
		33'h1_8412_a5_b5};
	bit_set_clear_exec u_bit_set_clear_exec (
		.clock       (clock),
		.rstn        (rstn),
		.instr_word  (instr_word),
		.instr_valid (instr_valid),
		.mem_rdata   (mem_rdata),
		.mem_rd_en   (mem_rd_en),
		.mem_addr    (mem_addr),
		.mem_wr_en   (mem_wr_en),
		.mem_wdata   (mem_wdata),
		.quarter     (quarter),
		.op_done     (op_done),
		.op_is_clear (op_is_clear),
		.flags_wr_en (flags_wr_en)
	);
	rf_model u_rf_model (
		.clock     (clock),
		.mem_rd_en (mem_rd_en),
		.mem_wr_en (mem_wr_en),
		.mem_addr  (mem_addr),
		.mem_wdata (mem_wdata),
		.mem_rdata (mem_rdata)
	);
	initial forever #25 clock = ~clock;
	initial begin #20000; n_mismatch++; results; end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clock);
		#1 rstn = 1;
		repeat (2) @(posedge clock);
		#1;
		while (quarter !== 2'h0) begin @(posedge clock); #1; end
		foreach (rows[i]) begin
			u_rf_model.regs[rows[i][23:16]] = rows[i][15:8];
			{instr_valid, instr_word} = rows[i][32:16];
			repeat (4) @(posedge clock);
			#1 chk(u_rf_model.regs[rows[i][23:16]], rows[i][7:0]);
			chk({7'h00, flags_wr_en}, 8'h00);
		end
		// A reset landing mid-instruction must abandon the write.
		u_rf_model.regs[8'h55] = 8'hc7;
		{instr_valid, instr_word} = 17'h1_8f55;
		@(posedge clock);
		#1 rstn = 0;
		repeat (3) @(posedge clock);
		#1 chk(u_rf_model.regs[8'h55], 8'hc7);
		chk({6'h00, quarter}, 8'h00);
		chk({5'h00, mem_rd_en, mem_wr_en, op_done}, 8'h00);
		// The word is withdrawn until the design has left reset again.
		instr_valid = 1'b0;
		@(posedge clock);
		#1 rstn = 1;
		repeat (2) @(posedge clock);
		#1 instr_valid = 1'b1;
		repeat (4) @(posedge clock);
		#1 chk(u_rf_model.regs[8'h55], 8'h47);
		results;
	end
endmodule // bit_set_clear_exec_tb
